// *** rtl/tsdr_regs.sv ***
// Purpose: Tile status bank: ring oscillator counters, RAM size, debug capture
// Assumes: Oscillator lines already synchronous to ref_clk; one access per cycle
// Notes: Counters have no reset so their contents survive system reset
// Functional notes
// - Four free-running oscillators each clock a counter; control register starts/stops them.
// - Control bit 1 enables core oscillators, bit 0 peripheral; reset zero.
// - Oscillators run unrelated to the tile clock, giving random bits.
// - Count registers 0x07-0x0A show counter in bits 15:0, upper zero.
// - Counts are kept through system reset.
// - Order: tile cell, tile wire, peripheral cell, peripheral wire.
// - Register 0x0C reads RAM size in bits 31:2, low bits zero.
// - Debugger entry captures saved status into 0x10.
// - Saved status field layout over bits 10 down to 0.
// - Debugger entry captures full saved program counter into 0x11.
// - Debugger entry captures full saved stack pointer into 0x12.
// - Register 0x13 bits 7:0 select the thread for debug register read.
// - Register 0x14 bits 4:0 select the register for debug register read.
// - Cause bits 2:0 encode host, call, ibreak, dwatch, rwatch; reset zero.
// - Bits 17:16 give lowest firing breakpoint; zero for host and call.
// - Bits 15:8 give causing thread; zero for host request.
// - Register 0x16 holds watch address or resource identifier.
`timescale 1ns/10ps
`default_nettype none
module tsdr_regs
  import tsdr_pkg::*;
#(
  parameter logic [31:0] RAM_BYTES = 32'h0002_0000
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Status register access
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [TSDR_ADDR_W-1:0] reg_addr,
  input wire logic [TSDR_DATA_W-1:0] reg_wdata,
  input wire logic debug_mode,
  output logic [TSDR_DATA_W-1:0] reg_rdata,
  output logic reg_rd_valid,
  // Ring oscillators
  output logic [1:0] osc_run,
  input wire logic [TSDR_OSC_NUM-1:0] osc_line,
  // Debugger entry
  input wire logic dbg_entry,
  input wire tsdr_dbg_entry_t dbg_info,
  output logic [7:0] read_thread_sel,
  output logic [4:0] read_reg_sel
);
  logic [1:0] osc_ctrl_q;
  logic [TSDR_OSC_NUM-1:0] osc_prev_q;
  // Power-up value only; reset never touches the counters
  logic [TSDR_CNT_W-1:0] cnt_q [TSDR_OSC_NUM] = '{default: '0};
  logic [TSDR_CNT_W-1:0] cnt_d [TSDR_OSC_NUM];
  logic [TSDR_OSC_NUM-1:0] osc_en;
  logic [31:0] status_q, pc_q, sp_q, cause_q, info_q;
  logic [7:0] thread_sel_q;
  logic [4:0] reg_sel_q;
  logic [31:0] rdata_q;
  logic rd_valid_q;

  // Access decode; debug registers writable only in debug mode
  wire dwr = reg_wr_en & debug_mode;
  wire wr_ctrl = reg_wr_en & (reg_addr == TSDR_OFS_OSC_CTRL);
  wire wr_status = dwr & (reg_addr == TSDR_OFS_SAVED_STATUS);
  wire wr_pc = dwr & (reg_addr == TSDR_OFS_SAVED_PC);
  wire wr_sp = dwr & (reg_addr == TSDR_OFS_SAVED_SP);
  wire wr_thread = dwr & (reg_addr == TSDR_OFS_READ_THREAD);
  wire wr_regsel = dwr & (reg_addr == TSDR_OFS_READ_REG);
  wire wr_cause = dwr & (reg_addr == TSDR_OFS_IRQ_CAUSE);
  wire wr_info = dwr & (reg_addr == TSDR_OFS_IRQ_INFO);

  // Oscillator control
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      osc_ctrl_q <= TSDR_OSC_CTRL_RST;
    end else if (wr_ctrl) begin
      osc_ctrl_q <= reg_wdata[1:0];
    end
  end
  assign osc_run = osc_ctrl_q;

  // Tile pair follows core enable, peripheral pair the peripheral enable
  assign osc_en = {{2{osc_ctrl_q[TSDR_OSC_PERIPH_BIT]}},
                   {2{osc_ctrl_q[TSDR_OSC_CORE_BIT]}}};

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      osc_prev_q <= '0;
    end else begin
      osc_prev_q <= osc_line;
    end
  end

  // Count rising edges of each oscillator line while enabled
  genvar gi;
  generate
    for (gi = 0; gi < TSDR_OSC_NUM; gi++) begin : g_cnt
      wire step = osc_en[gi] & osc_line[gi] & ~osc_prev_q[gi];
      assign cnt_d[gi] = step ? cnt_q[gi] + 1'b1 : cnt_q[gi];
      // No reset here: contents must survive a system reset
      always_ff @(posedge ref_clk) begin
        cnt_q[gi] <= cnt_d[gi];
      end
    end
  endgenerate

  // Lowest numbered firing breakpoint wins
  function automatic logic [1:0] lowest_hit(input logic [3:0] hits);
    logic [1:0] n;
    n = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (hits[i]) begin
        n = i[1:0];
      end
    end
    return n;
  endfunction

  wire is_bp = (dbg_info.cause == TSDR_CAUSE_IBRK) |
               (dbg_info.cause == TSDR_CAUSE_DWATCH) |
               (dbg_info.cause == TSDR_CAUSE_RWATCH);
  wire is_host = dbg_info.cause == TSDR_CAUSE_HOST;
  wire [1:0] cap_bpnum = is_bp ? lowest_hit(dbg_info.hits) : 2'h0;
  wire [7:0] cap_thread = is_host ? 8'h00 : dbg_info.thread;
  wire [31:0] cap_cause = {14'h0000, cap_bpnum, cap_thread, 5'h00,
                           dbg_info.cause};
  wire keep_info = (dbg_info.cause == TSDR_CAUSE_DWATCH) |
                   (dbg_info.cause == TSDR_CAUSE_RWATCH);

  // Capture on entry wins over a software write in the same cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      status_q <= TSDR_ZERO;
      pc_q <= TSDR_ZERO;
      sp_q <= TSDR_ZERO;
      cause_q <= TSDR_ZERO;
      info_q <= TSDR_ZERO;
    end else if (dbg_entry) begin
      status_q <= dbg_info.status & TSDR_STATUS_CMASK;
      pc_q <= dbg_info.pc;
      sp_q <= dbg_info.sp;
      cause_q <= cap_cause;
      if (keep_info) begin
        info_q <= dbg_info.info;
      end
    end else begin
      // Bit 8 is read-only: software keeps the captured value
      if (wr_status) begin
        status_q <= (reg_wdata & TSDR_STATUS_WMASK) |
                    (status_q & ~TSDR_STATUS_WMASK & TSDR_STATUS_CMASK);
      end
      if (wr_pc) begin
        pc_q <= reg_wdata;
      end
      if (wr_sp) begin
        sp_q <= reg_wdata;
      end
      if (wr_cause) begin
        cause_q <= reg_wdata & TSDR_CAUSE_MASK;
      end
      if (wr_info) begin
        info_q <= reg_wdata;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      thread_sel_q <= 8'h00;
      reg_sel_q <= 5'h00;
    end else begin
      if (wr_thread) begin
        thread_sel_q <= reg_wdata[7:0];
      end
      if (wr_regsel) begin
        reg_sel_q <= reg_wdata[4:0];
      end
    end
  end
  assign read_thread_sel = thread_sel_q;
  assign read_reg_sel = reg_sel_q;

  // Read selection; unmapped numbers read zero
  wire [31:0] rd_word =
    (reg_addr == TSDR_OFS_OSC_CTRL) ? {30'h0000_0000, osc_ctrl_q} :
    (reg_addr == TSDR_OFS_CNT_TILE_CELL) ? {16'h0000, cnt_q[0]} :
    (reg_addr == TSDR_OFS_CNT_TILE_WIRE) ? {16'h0000, cnt_q[1]} :
    (reg_addr == TSDR_OFS_CNT_PERIPH_CELL) ? {16'h0000, cnt_q[2]} :
    (reg_addr == TSDR_OFS_CNT_PERIPH_WIRE) ? {16'h0000, cnt_q[3]} :
    (reg_addr == TSDR_OFS_RAM_SIZE) ? (RAM_BYTES & TSDR_RAM_MASK) :
    (reg_addr == TSDR_OFS_SAVED_STATUS) ? status_q :
    (reg_addr == TSDR_OFS_SAVED_PC) ? pc_q :
    (reg_addr == TSDR_OFS_SAVED_SP) ? sp_q :
    (reg_addr == TSDR_OFS_READ_THREAD) ? {24'h00_0000, thread_sel_q} :
    (reg_addr == TSDR_OFS_READ_REG) ? {27'h000_0000, reg_sel_q} :
    (reg_addr == TSDR_OFS_IRQ_CAUSE) ? cause_q :
    (reg_addr == TSDR_OFS_IRQ_INFO) ? info_q : TSDR_ZERO;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rdata_q <= TSDR_ZERO;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= reg_rd_en;
      if (reg_rd_en) begin
        rdata_q <= rd_word;
      end
    end
  end
  assign reg_rdata = rdata_q;
  assign reg_rd_valid = rd_valid_q;

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence s_entry;
    dbg_entry;
  endsequence
  sequence s_rd(logic [7:0] a);
    reg_rd_en && reg_addr == a;
  endsequence

  property p_ctrl_wr;
    wr_ctrl |=> osc_run == $past(reg_wdata[1:0]);
  endproperty
  a_ctrl_wr: assert property (p_ctrl_wr) else $error("osc control write lost");

  property p_cnt_hold;
    !osc_run[TSDR_OSC_CORE_BIT] |=> cnt_q[0] == $past(cnt_q[0]);
  endproperty
  a_cnt_hold: assert property (p_cnt_hold) else $error("count moved while off");

  property p_cnt_step;
    osc_en[2] && osc_line[2] && !osc_prev_q[2] |=> cnt_q[2] == $past(cnt_q[2]) + 16'h0001;
  endproperty
  a_cnt_step: assert property (p_cnt_step) else $error("count missed edge");

  property p_cnt_read;
    s_rd(TSDR_OFS_CNT_PERIPH_WIRE) |=> reg_rd_valid && reg_rdata == {16'h0000, $past(cnt_q[3])};
  endproperty
  a_cnt_read: assert property (p_cnt_read) else $error("count readback wrong");

  property p_ram_read;
    s_rd(TSDR_OFS_RAM_SIZE) |=> reg_rdata == (RAM_BYTES & TSDR_RAM_MASK);
  endproperty
  a_ram_read: assert property (p_ram_read) else $error("RAM size wrong");

  property p_cap_pc_sp;
    s_entry |=> pc_q == $past(dbg_info.pc) && sp_q == $past(dbg_info.sp);
  endproperty
  a_cap_pc_sp: assert property (p_cap_pc_sp) else $error("pc or sp not captured");

  property p_cap_status;
    s_entry |=> status_q == ($past(dbg_info.status) & TSDR_STATUS_CMASK);
  endproperty
  a_cap_status: assert property (p_cap_status) else $error("status not captured");

  property p_host_zero;
    s_entry and is_host |=> cause_q[17:8] == 10'h000 && cause_q[2:0] == TSDR_CAUSE_HOST;
  endproperty
  a_host_zero: assert property (p_host_zero) else $error("host cause fields wrong");

  property p_lowest;
    s_entry and (is_bp && dbg_info.hits == 4'h6) |=> cause_q[17:16] == 2'h1;
  endproperty
  a_lowest: assert property (p_lowest) else $error("breakpoint not lowest");

  property p_sel;
    wr_thread && !wr_regsel |=> read_thread_sel == $past(reg_wdata[7:0]) ##1
      read_thread_sel == $past(read_thread_sel) || $past(wr_thread);
  endproperty
  a_sel: assert property (p_sel) else $error("thread select wrong");

  property p_rsvd;
    s_rd(TSDR_OFS_READ_REG) |=> reg_rdata[31:5] == 27'h000_0000;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");

  property p_info_cap;
    s_entry and keep_info |=> info_q == $past(dbg_info.info);
  endproperty
  a_info_cap: assert property (p_info_cap) else $error("watch data not captured");

  property p_regsel_wr;
    wr_regsel |=> read_reg_sel == $past(reg_wdata[4:0]);
  endproperty
  a_regsel_wr: assert property (p_regsel_wr) else $error("register select wrong");

  // Debug registers must ignore writes outside debug mode
  property p_pc_locked;
    reg_wr_en && !debug_mode && !dbg_entry && reg_addr == TSDR_OFS_SAVED_PC |=>
      pc_q == $past(pc_q);
  endproperty
  a_pc_locked: assert property (p_pc_locked) else $error("pc written outside debug");

  // Checked through reset itself, so the default disable is overridden
  property p_cnt_keep;
    disable iff (1'b0) reset && !osc_run[TSDR_OSC_CORE_BIT] |=> cnt_q[1] == $past(cnt_q[1]);
  endproperty
  a_cnt_keep: assert property (p_cnt_keep) else $error("count cleared by reset");
endmodule
`default_nettype wire

// *** common/tsdr_pkg.sv ***
// Purpose: Shared constants and types for the tile status and debug bank
// Assumes: Word-indexed status register numbers, 32-bit data
// Notes: Masks give the implemented bits; other bits read as zero
package tsdr_pkg;
  localparam int TSDR_DATA_W = 32;
  localparam int TSDR_ADDR_W = 8;
  localparam int TSDR_CNT_W = 16;
  localparam int TSDR_OSC_NUM = 4;
  // Register numbers
  localparam logic [7:0] TSDR_OFS_OSC_CTRL = 8'h06;
  localparam logic [7:0] TSDR_OFS_CNT_TILE_CELL = 8'h07;
  localparam logic [7:0] TSDR_OFS_CNT_TILE_WIRE = 8'h08;
  localparam logic [7:0] TSDR_OFS_CNT_PERIPH_CELL = 8'h09;
  localparam logic [7:0] TSDR_OFS_CNT_PERIPH_WIRE = 8'h0a;
  localparam logic [7:0] TSDR_OFS_RAM_SIZE = 8'h0c;
  localparam logic [7:0] TSDR_OFS_SAVED_STATUS = 8'h10;
  localparam logic [7:0] TSDR_OFS_SAVED_PC = 8'h11;
  localparam logic [7:0] TSDR_OFS_SAVED_SP = 8'h12;
  localparam logic [7:0] TSDR_OFS_READ_THREAD = 8'h13;
  localparam logic [7:0] TSDR_OFS_READ_REG = 8'h14;
  localparam logic [7:0] TSDR_OFS_IRQ_CAUSE = 8'h15;
  localparam logic [7:0] TSDR_OFS_IRQ_INFO = 8'h16;
  // Oscillator control fields
  localparam int TSDR_OSC_CORE_BIT = 1;
  localparam int TSDR_OSC_PERIPH_BIT = 0;
  localparam logic [1:0] TSDR_OSC_CTRL_RST = 2'h0;
  // Field masks
  localparam logic [31:0] TSDR_STATUS_WMASK = 32'h0000_06df;
  localparam logic [31:0] TSDR_STATUS_CMASK = 32'h0000_07df;
  localparam logic [31:0] TSDR_RAM_MASK = 32'hffff_fffc;
  localparam logic [31:0] TSDR_CAUSE_MASK = 32'h0003_ff07;
  localparam int TSDR_CAUSE_LSB = 0;
  localparam int TSDR_THREAD_LSB = 8;
  localparam int TSDR_BPNUM_LSB = 16;
  localparam logic [31:0] TSDR_ZERO = 32'h0000_0000;
  // Debug cause codes
  localparam logic [2:0] TSDR_CAUSE_NONE = 3'h0;
  localparam logic [2:0] TSDR_CAUSE_HOST = 3'h1;
  localparam logic [2:0] TSDR_CAUSE_DEBUG_CALL_INSTRUCTION = 3'h2;
  localparam logic [2:0] TSDR_CAUSE_IBRK = 3'h3;
  localparam logic [2:0] TSDR_CAUSE_DWATCH = 3'h4;
  localparam logic [2:0] TSDR_CAUSE_RWATCH = 3'h5;
  // Settle time software waits after stopping oscillators
  localparam int TSDR_STOP_SETTLE_CYC = 10;

  typedef struct packed {
    logic [31:0] status;
    logic [31:0] pc;
    logic [31:0] sp;
    logic [7:0] thread;
    logic [2:0] cause;
    logic [3:0] hits;
    logic [31:0] info;
  } tsdr_dbg_entry_t;
endpackage

// *** test/tsdr_osc_model.sv ***
// Purpose: Ring oscillator stand-in driving the bank's counter inputs
// Assumes: Lines change on ref_clk; true asynchrony is not modelled
// Notes: A stopped lane holds its level so no false edge is counted
`timescale 1ns/10ps
`default_nettype none
module tsdr_osc_model (
  // Clock
  input wire logic ref_clk,
  // Oscillator control and lines
  input wire logic [1:0] osc_run,
  output logic [3:0] osc_line
);
  logic [3:0] div_q = 4'h0;
  logic [3:0] line_q = 4'h0;
  assign osc_line = line_q;
  always_ff @(posedge ref_clk) begin
    div_q <= div_q + 4'h1;
    // Lanes 0-1 core, 2-3 peripheral, each at its own rate
    line_q[1:0] <= osc_run[1] ? div_q[1:0] : line_q[1:0];
    line_q[3:2] <= osc_run[0] ? div_q[3:2] : line_q[3:2];
  end
endmodule
`default_nettype wire

// *** test/testbench.sv ***
// Purpose: Self-checking bench for the tile status and debug bank
// Assumes: Read data valid one cycle after the request edge
// Notes: Counters power up at zero; counts are compared as moved or held
`timescale 1ns/10ps
`default_nettype none
module testbench import tsdr_pkg::*; ;
  typedef struct packed {logic [7:0] a; logic [31:0] w; logic dm; logic [31:0] e;} tsdr_row_t;
  localparam tsdr_row_t ROWS [0:12] = '{
    '{8'h06, 32'hffff_ffff, 1'b0, 32'h0000_0003},
    '{8'h06, 32'h0000_0001, 1'b0, 32'h0000_0001},
    '{8'h06, 32'h0000_0000, 1'b0, 32'h0000_0000},
    '{8'h13, 32'hffff_ffff, 1'b1, 32'h0000_00ff},
    '{8'h14, 32'hffff_ffff, 1'b1, 32'h0000_001f},
    '{8'h10, 32'hffff_ffff, 1'b1, 32'h0000_06df},
    '{8'h11, 32'ha5a5_5a5a, 1'b1, 32'ha5a5_5a5a},
    '{8'h11, 32'h1234_5678, 1'b0, 32'ha5a5_5a5a},
    '{8'h12, 32'h5a5a_a5a5, 1'b1, 32'h5a5a_a5a5},
    '{8'h15, 32'hffff_ffff, 1'b1, 32'h0003_ff07},
    '{8'h16, 32'hdead_beef, 1'b1, 32'hdead_beef},
    '{8'h0c, 32'hffff_ffff, 1'b1, 32'h0001_2344},
    '{8'h0b, 32'hffff_ffff, 1'b1, 32'h0000_0000}
  };
  logic ref_clk, reset, reg_wr_en, reg_rd_en, debug_mode, reg_rd_valid, dbg_entry;
  logic [7:0] reg_addr, read_thread_sel;
  logic [31:0] reg_wdata, reg_rdata, e, prev;
  logic [1:0] osc_run;
  logic [3:0] osc_line;
  logic [4:0] read_reg_sel;
  tsdr_dbg_entry_t dbg_info;
  logic [31:0] cnt_a [4];
  logic [31:0] cnt_b [4];
  logic [31:0] cnt_c [4];
  int n_errors = 0;
  int n_checks = 0;

  tsdr_regs #(.RAM_BYTES(32'h0001_2347)) i_tsdr_regs (
    .ref_clk(ref_clk), .reset(reset), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .debug_mode(debug_mode),
    .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .osc_run(osc_run),
    .osc_line(osc_line), .dbg_entry(dbg_entry), .dbg_info(dbg_info),
    .read_thread_sel(read_thread_sel), .read_reg_sel(read_reg_sel)
  );
  tsdr_osc_model i_tsdr_osc_model (.ref_clk(ref_clk), .osc_run(osc_run), .osc_line(osc_line));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic give_verdict();
    $display("Checks %0d, errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic dm);
    @(posedge ref_clk);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    debug_mode <= dm;
    @(posedge ref_clk);
    reg_wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_rd_en <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd_en <= 1'b0;
    #1;
    chk({31'h0, reg_rd_valid}, 32'h1);
    d = reg_rdata;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(d, exp);
  endtask

  task automatic do_reset();
    @(posedge ref_clk);
    reset <= 1'b1;
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
  endtask

  // Hang guard
  initial begin
    #200us;
    n_errors++;
    give_verdict();
  end

  initial begin
    reset = 1'b1;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    debug_mode = 1'b0;
    dbg_entry = 1'b0;
    dbg_info = '0;
    do_reset();
    chk({30'h0, osc_run}, 32'h0);
    rc(TSDR_OFS_OSC_CTRL, 32'h0);
    rc(TSDR_OFS_IRQ_CAUSE, 32'h0);
    foreach (ROWS[i]) begin
      wr(ROWS[i].a, ROWS[i].w, ROWS[i].dm);
      rc(ROWS[i].a, ROWS[i].e);
      if (ROWS[i].a == TSDR_OFS_OSC_CTRL) begin
        chk({30'h0, osc_run}, ROWS[i].e);
      end
    end
    chk({24'h0, read_thread_sel}, 32'h0000_00ff);
    chk({27'h0, read_reg_sel}, 32'h0000_001f);
    // Core lanes only; peripheral counts must not move
    for (int i = 0; i < 4; i++) rd(TSDR_OFS_CNT_TILE_CELL + 8'(i), cnt_a[i]);
    wr(TSDR_OFS_OSC_CTRL, 32'h0000_0002, 1'b0);
    repeat (20) @(posedge ref_clk);
    wr(TSDR_OFS_OSC_CTRL, 32'h0000_0000, 1'b0);
    repeat (TSDR_STOP_SETTLE_CYC) @(posedge ref_clk);
    for (int i = 0; i < 4; i++) begin
      rd(TSDR_OFS_CNT_TILE_CELL + 8'(i), cnt_b[i]);
      chk(cnt_b[i] & 32'hffff_0000, 32'h0);
      if (i >= 2) begin
        chk(cnt_b[i], cnt_a[i]);
      end else begin
        chk({31'h0, cnt_b[i] !== cnt_a[i]}, 32'h1);
      end
    end
    // Peripheral lanes only; core counts must not move
    wr(TSDR_OFS_OSC_CTRL, 32'h0000_0001, 1'b0);
    repeat (40) @(posedge ref_clk);
    wr(TSDR_OFS_OSC_CTRL, 32'h0000_0000, 1'b0);
    repeat (TSDR_STOP_SETTLE_CYC) @(posedge ref_clk);
    for (int i = 0; i < 4; i++) begin
      rd(TSDR_OFS_CNT_TILE_CELL + 8'(i), cnt_a[i]);
      chk({31'h0, cnt_a[i] !== cnt_b[i]}, {31'h0, i >= 2});
    end
    // Nonzero core counts make a clearing reset visible
    do_reset();
    for (int i = 0; i < 4; i++) begin
      rd(TSDR_OFS_CNT_TILE_CELL + 8'(i), cnt_c[i]);
      chk(cnt_c[i], cnt_a[i]);
    end
    rc(TSDR_OFS_OSC_CTRL, 32'h0);
    rc(TSDR_OFS_READ_THREAD, 32'h0);
    prev = 32'h0000_0000;
    for (int c = 1; c <= 5; c++) begin
      @(posedge ref_clk);
      dbg_entry <= 1'b1;
      dbg_info.status <= 32'hffff_ffff;
      dbg_info.pc <= 32'hc0de_0000 + 32'(c);
      dbg_info.sp <= 32'h5000_0000 + 32'(c);
      dbg_info.thread <= 8'h2a;
      dbg_info.cause <= 3'(c);
      dbg_info.hits <= (c < 3) ? 4'hf : 4'(4'hc >> (c - 3));
      dbg_info.info <= 32'h0000_0100 + 32'(c);
      @(posedge ref_clk);
      dbg_entry <= 1'b0;
      if (c >= 4) begin
        prev = 32'h0000_0100 + 32'(c);
      end
      e = {14'h0, (c >= 3) ? 2'(5 - c) : 2'h0, (c == 1) ? 8'h00 : 8'h2a, 5'h0, 3'(c)};
      rc(TSDR_OFS_SAVED_STATUS, 32'h0000_07df);
      rc(TSDR_OFS_SAVED_PC, 32'hc0de_0000 + 32'(c));
      rc(TSDR_OFS_SAVED_SP, 32'h5000_0000 + 32'(c));
      rc(TSDR_OFS_IRQ_CAUSE, e);
      rc(TSDR_OFS_IRQ_INFO, prev);
    end
    give_verdict();
  end
endmodule
`default_nettype wire
